// ### pcs_pkg.sv
// Purpose: shared constants and carriers for pc sequencing and indirect access
// Assumes: 8-bit data path, 13-bit program space
// Notes: no register bus; control arrives as plain ports
package pcs_pkg;
  localparam int PC_W = 13;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 9;
  localparam int STACK_DEPTH = 8;
  localparam int SP_W = 3;
  localparam int OPND_W = 11;
  localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
  localparam logic [DATA_W-1:0] LATCH_RESET = 8'h00;
  localparam logic [DATA_W-1:0] PTR_RESET = 8'h00;
  localparam logic [SP_W-1:0] SP_RESET = 3'h0;
  localparam logic [DATA_W-1:0] INDIRECT_REG_ADDR = 8'h00;
  localparam logic [DATA_W-1:0] INDIRECT_ZERO = 8'h00;
  localparam logic [PC_W-1:0] PC_ONE = 13'h0001;
  localparam logic [PC_W-1:0] INT_VECTOR = 13'h0004;

  // one program-flow operation per instruction cycle
  typedef enum logic [2:0] {
    PCS_OP_NONE,
    PCS_OP_STEP,
    PCS_OP_CALL,
    PCS_OP_JUMP,
    PCS_OP_RETURN,
    PCS_OP_INTR
  } pcs_op_t;

  // data-side access: address, write strobe, write data
  typedef struct packed {
    logic [DATA_W-1:0] addr;
    logic wr;
    logic [DATA_W-1:0] wdata;
  } pcs_access_t;

  // indirect access routed out to data memory
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic wr;
    logic rd;
    logic [DATA_W-1:0] wdata;
  } pcs_indirect_t;
endpackage : pcs_pkg

// ### pcs_core.sv
// Purpose: program counter, return stack and indirect data addressing
// Assumes: one op per cycle from the decoder, data regs addressed by offset
// Notes: stack has no overflow status by design
// What this block does
// - 13-bit counter, low byte readable and writable
// - upper bits only via upper latch
// - any reset clears whole counter
// - low byte write loads bits from latch
// - call/jump take top bits from latch
// - eight by thirteen stack, hidden pointer
// - call or interrupt pushes counter
// - returns pop stack into counter
// - push and pop leave latch alone
// - stack wraps circularly, overwriting oldest
// - no overflow or underflow status
// - indirect register redirects through pointer
// - indirect read of itself gives zero
// - indirect write of itself stores nothing
// - address is bank bit over pointer
`timescale 1ns/10ps
`default_nettype none
module pcs_core #(
  parameter int DEPTH = pcs_pkg::STACK_DEPTH
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RESET,
  // program flow control from the decoder
  input wire pcs_pkg::pcs_op_t OP,
  input wire logic [pcs_pkg::OPND_W-1:0] OPERAND,
  // register access to counter low byte, latch and pointer
  input wire pcs_pkg::pcs_access_t ACCESS,
  input wire logic PC_LOW_SEL,
  input wire logic LATCH_SEL,
  input wire logic PTR_SEL,
  input wire logic INDIRECT_BANK_BIT,
  // indirect data memory side
  input wire logic [pcs_pkg::DATA_W-1:0] MEM_RDATA,
  output pcs_pkg::pcs_indirect_t MEM_REQ,
  // state visible to the core
  output logic [pcs_pkg::PC_W-1:0] PC,
  output logic [pcs_pkg::DATA_W-1:0] PC_LOW_REG,
  output logic [pcs_pkg::DATA_W-1:0] PC_UPPER_LATCH,
  output logic [pcs_pkg::DATA_W-1:0] FILE_SELECT_POINTER,
  output logic [pcs_pkg::DATA_W-1:0] INDIRECT_RDATA
);

  //--------------------------------------------------------------
  // storage
  //--------------------------------------------------------------
  logic [pcs_pkg::PC_W-1:0] pc_q, pc_d;
  logic [pcs_pkg::DATA_W-1:0] latch_q, latch_d;
  logic [pcs_pkg::DATA_W-1:0] ptr_q, ptr_d;
  logic [pcs_pkg::SP_W-1:0] sp_q, sp_d;
  logic [pcs_pkg::PC_W-1:0] stack_q [DEPTH];
  pcs_pkg::pcs_indirect_t req_q, req_d;
  logic [pcs_pkg::DATA_W-1:0] ird_q, ird_d;

  //--------------------------------------------------------------
  // decode
  //--------------------------------------------------------------
  // pointer plus one (up) or minus one (down), wrapping modulo the stack depth
  function automatic logic [pcs_pkg::SP_W-1:0] sp_step(
    input logic [pcs_pkg::SP_W-1:0] sp, input logic up);
    logic [pcs_pkg::SP_W-1:0] r;
    r = up ? sp + pcs_pkg::SP_W'(1) : sp - pcs_pkg::SP_W'(1);
    return r;
  endfunction

  // the indirect register is addressed: access is redirected
  wire ind_hit = (ACCESS.addr == pcs_pkg::INDIRECT_REG_ADDR);
  // pointer selecting the indirect register itself
  wire ind_self = (ptr_q == pcs_pkg::INDIRECT_REG_ADDR);
  wire do_push = (OP == pcs_pkg::PCS_OP_CALL) ||
                 (OP == pcs_pkg::PCS_OP_INTR);
  wire do_pop = (OP == pcs_pkg::PCS_OP_RETURN);
  wire low_wr = ACCESS.wr && PC_LOW_SEL && !ind_hit;
  // top of stack is the slot just below the pointer
  wire [pcs_pkg::SP_W-1:0] top_idx = sp_step(sp_q, 1'b0);
  // call/jump target: two latch bits over the eleven operand bits
  wire [pcs_pkg::PC_W-1:0] jump_pc = {latch_q[4:3], OPERAND};
  // low byte write: five latch bits over the written byte
  wire [pcs_pkg::PC_W-1:0] low_pc = {latch_q[4:0], ACCESS.wdata};
  // nine-bit indirect address
  wire [pcs_pkg::ADDR_W-1:0] ind_addr = {INDIRECT_BANK_BIT, ptr_q};

  //--------------------------------------------------------------
  // next counter; a low-byte write wins over the sequential step
  //--------------------------------------------------------------
  always_comb begin
    pc_d = pc_q;
    case (OP)
      pcs_pkg::PCS_OP_STEP: pc_d = pc_q + pcs_pkg::PC_ONE;
      pcs_pkg::PCS_OP_CALL: pc_d = jump_pc;
      pcs_pkg::PCS_OP_JUMP: pc_d = jump_pc;
      pcs_pkg::PCS_OP_RETURN: pc_d = stack_q[top_idx];
      pcs_pkg::PCS_OP_INTR: pc_d = pcs_pkg::INT_VECTOR;
      default: pc_d = pc_q;
    endcase
    if (low_wr && (OP == pcs_pkg::PCS_OP_NONE ||
                   OP == pcs_pkg::PCS_OP_STEP)) begin
      pc_d = low_pc;
    end
  end

  //--------------------------------------------------------------
  // stack pointer: free-running wrap, no status kept
  //--------------------------------------------------------------
  always_comb begin
    sp_d = sp_q;
    if (do_push) begin
      sp_d = sp_step(sp_q, 1'b1);
    end else if (do_pop) begin
      sp_d = top_idx;
    end
  end

  //--------------------------------------------------------------
  // latch and pointer writes; stack ops never touch the latch
  //--------------------------------------------------------------
  always_comb begin
    latch_d = latch_q;
    ptr_d = ptr_q;
    if (ACCESS.wr && LATCH_SEL && !ind_hit) begin
      latch_d = ACCESS.wdata;
    end
    if (ACCESS.wr && PTR_SEL && !ind_hit) begin
      ptr_d = ACCESS.wdata;
    end
  end

  //--------------------------------------------------------------
  // indirect access out to memory
  //--------------------------------------------------------------
  always_comb begin
    req_d.addr = ind_addr;
    req_d.wdata = ACCESS.wdata;
    req_d.rd = ind_hit && !ACCESS.wr && !ind_self;
    // a self-pointing write is dropped; flags are the core's concern
    req_d.wr = ind_hit && ACCESS.wr && !ind_self;
    // self-pointing read returns zero, else the memory byte
    ird_d = ind_self ? pcs_pkg::INDIRECT_ZERO : MEM_RDATA;
  end

  //--------------------------------------------------------------
  // registers
  //--------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (RESET) begin
      pc_q <= pcs_pkg::PC_RESET;
      latch_q <= pcs_pkg::LATCH_RESET;
      ptr_q <= pcs_pkg::PTR_RESET;
      sp_q <= pcs_pkg::SP_RESET;
      req_q <= '0;
      ird_q <= pcs_pkg::INDIRECT_ZERO;
    end else begin
      pc_q <= pc_d;
      latch_q <= latch_d;
      ptr_q <= ptr_d;
      sp_q <= sp_d;
      req_q <= req_d;
      ird_q <= ird_d;
    end
  end

  // stack array has no reset; contents are undefined until pushed
  always_ff @(posedge CLK) begin
    if (!RESET && do_push) begin
      stack_q[sp_q] <= (OP == pcs_pkg::PCS_OP_INTR) ? pc_q :
                       pc_q + pcs_pkg::PC_ONE;
    end
  end

  //--------------------------------------------------------------
  // outputs, all from flip-flops
  //--------------------------------------------------------------
  assign PC = pc_q;
  assign PC_LOW_REG = pc_q[7:0];
  assign PC_UPPER_LATCH = latch_q;
  assign FILE_SELECT_POINTER = ptr_q;
  assign MEM_REQ = req_q;
  assign INDIRECT_RDATA = ird_q;

endmodule // pcs_core
`default_nettype wire

// ### pcs_core_checker.sv
// Purpose: port-level checks for pcs_core
// Assumes: one clock, synchronous active-high reset
// Notes: bound to every pcs_core instance
`timescale 1ns/10ps
`default_nettype none
module pcs_core_checker (
  // clock and reset
  input wire logic CLK,
  input wire logic RESET,
  // inputs seen by the core
  input wire pcs_pkg::pcs_op_t OP,
  input wire logic [10:0] OPERAND,
  input wire pcs_pkg::pcs_access_t ACCESS,
  input wire logic PC_LOW_SEL,
  input wire logic LATCH_SEL,
  input wire logic INDIRECT_BANK_BIT,
  input wire logic [7:0] MEM_RDATA,
  // outputs of the core
  input wire pcs_pkg::pcs_indirect_t MEM_REQ,
  input wire logic [12:0] PC,
  input wire logic [7:0] PC_UPPER_LATCH,
  input wire logic [7:0] FILE_SELECT_POINTER,
  input wire logic [7:0] INDIRECT_RDATA
);
  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);
  // named decodes keep the properties short
  wire ind = ACCESS.addr == 8'h00;
  wire ptr0 = FILE_SELECT_POINTER == 8'h00;
  wire low_wr = ACCESS.wr && PC_LOW_SEL && !ind;
  step_add_a: assert property (
    OP == pcs_pkg::PCS_OP_STEP && !low_wr |=>
    PC == $past(PC) + 13'h0001) else $error("step did not add one");
  call_jump_a: assert property (OP inside {pcs_pkg::PCS_OP_CALL,
    pcs_pkg::PCS_OP_JUMP} |=> PC == {$past(PC_UPPER_LATCH[4:3]),
    $past(OPERAND)}) else $error("call or jump target wrong");
  low_load_a: assert property (OP inside {pcs_pkg::PCS_OP_NONE,
    pcs_pkg::PCS_OP_STEP} && low_wr |=> PC == {$past(PC_UPPER_LATCH[4:0]),
    $past(ACCESS.wdata)}) else $error("low byte load wrong");
  intr_vector_a: assert property (OP == pcs_pkg::PCS_OP_INTR |=>
    PC == pcs_pkg::INT_VECTOR) else $error("interrupt vector wrong");
  latch_keep_a: assert property (OP inside {pcs_pkg::PCS_OP_CALL,
    pcs_pkg::PCS_OP_RETURN, pcs_pkg::PCS_OP_INTR} && !LATCH_SEL |=>
    $stable(PC_UPPER_LATCH)) else $error("latch moved on stack use");
  ind_route_a: assert property (ind && !ACCESS.wr && !ptr0 |=>
    MEM_REQ.rd && MEM_REQ.addr == {$past(INDIRECT_BANK_BIT),
    $past(FILE_SELECT_POINTER)} && INDIRECT_RDATA == $past(MEM_RDATA))
    else $error("indirect read misrouted");
  self_read_a: assert property (ind && !ACCESS.wr && ptr0 |=>
    INDIRECT_RDATA == 8'h00 && !MEM_REQ.rd) else $error("self read not zero");
  self_write_a: assert property (ind && ACCESS.wr && ptr0 |=>
    !MEM_REQ.wr) else $error("self write reached memory");
endmodule // pcs_core_checker
bind pcs_core pcs_core_checker chk (.CLK(CLK), .RESET(RESET), .OP(OP),
  .OPERAND(OPERAND), .ACCESS(ACCESS), .PC_LOW_SEL(PC_LOW_SEL),
  .LATCH_SEL(LATCH_SEL), .INDIRECT_BANK_BIT(INDIRECT_BANK_BIT),
  .MEM_RDATA(MEM_RDATA), .MEM_REQ(MEM_REQ), .PC(PC),
  .PC_UPPER_LATCH(PC_UPPER_LATCH), .FILE_SELECT_POINTER(FILE_SELECT_POINTER),
  .INDIRECT_RDATA(INDIRECT_RDATA));
`default_nettype wire

// ### tb_pcs_core.sv
// Purpose: self-checking bench for pcs_core
// Assumes: 100 MHz clock, reset held for 20 cycles
// Notes: ordinary cases from a row table, stack and indirect by hand
`timescale 1ns/10ps
`default_nettype none
module tb_pcs_core;
  typedef struct packed {
    pcs_pkg::pcs_op_t op;
    logic [10:0] opnd;
    logic [7:0] addr;
    logic wr;
    logic [7:0] wd;
    logic [2:0] sel;
    logic [12:0] pc;
  } pcs_row_t;
  logic CLK = 1'b0;
  logic RESET = 1'b1;
  pcs_pkg::pcs_op_t op = pcs_pkg::PCS_OP_NONE;
  logic [10:0] opnd = 11'h000;
  pcs_pkg::pcs_access_t acc = '{8'h7F, 1'b0, 8'h00};
  logic [2:0] sel = 3'h0;
  logic bank = 1'b1;
  logic [7:0] rdata = 8'hA5;
  pcs_pkg::pcs_indirect_t req;
  logic [12:0] pc;
  logic [7:0] pc_low_reg, lat, ptr, ird;
  int bad_count = 0;
  int check_count = 0;
  pcs_row_t rows [9];
  always #5 CLK = ~CLK;
  pcs_core dut (.CLK(CLK), .RESET(RESET), .OP(op), .OPERAND(opnd),
    .ACCESS(acc), .PC_LOW_SEL(sel[2]), .LATCH_SEL(sel[1]), .PTR_SEL(sel[0]),
    .INDIRECT_BANK_BIT(bank), .MEM_RDATA(rdata), .MEM_REQ(req), .PC(pc),
    .PC_LOW_REG(pc_low_reg), .PC_UPPER_LATCH(lat), .FILE_SELECT_POINTER(ptr),
    .INDIRECT_RDATA(ird));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [12:0] exp, got);
    check_count++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", nm, exp, got);
      bad_count++;
    end
  endtask
  // inputs move 1 ns after an edge so no race with the core's sampling
  task automatic apply(input pcs_pkg::pcs_op_t o, input logic [10:0] n,
    input logic [7:0] a, input logic w, input logic [7:0] d,
    input logic [2:0] s);
    op = o;
    opnd = n;
    acc = '{a, w, d};
    sel = s;
    @(posedge CLK);
    #1;
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // watchdog: the whole run needs well under 200 cycles
  initial begin
    #20000;
    bad_count++;
    conclude();
  end
  initial begin
    // op, operand, addr, wr, wdata, sel {low, latch, ptr}, pc after
    rows = '{
      '{pcs_pkg::PCS_OP_NONE, 11'h000, 8'h0A, 1'b1, 8'h1B, 3'h2, 13'h0000},
      '{pcs_pkg::PCS_OP_STEP, 11'h000, 8'h7F, 1'b0, 8'h00, 3'h0, 13'h0001},
      '{pcs_pkg::PCS_OP_CALL, 11'h123, 8'h7F, 1'b0, 8'h00, 3'h0, 13'h1923},
      '{pcs_pkg::PCS_OP_JUMP, 11'h7FF, 8'h7F, 1'b0, 8'h00, 3'h0, 13'h1FFF},
      '{pcs_pkg::PCS_OP_STEP, 11'h000, 8'h7F, 1'b0, 8'h00, 3'h0, 13'h0000},
      '{pcs_pkg::PCS_OP_STEP, 11'h000, 8'h0A, 1'b1, 8'h40, 3'h4, 13'h1B40},
      '{pcs_pkg::PCS_OP_RETURN, 11'h000, 8'h7F, 1'b0, 8'h00, 3'h0, 13'h0002},
      '{pcs_pkg::PCS_OP_INTR, 11'h000, 8'h7F, 1'b0, 8'h00, 3'h0, 13'h0004},
      '{pcs_pkg::PCS_OP_RETURN, 11'h000, 8'h7F, 1'b0, 8'h00, 3'h0, 13'h0002}};
    repeat (20) @(posedge CLK);
    #1;
    chk("pc in reset", 13'h0000, pc);
    RESET = 1'b0;
    foreach (rows[i]) begin
      apply(rows[i].op, rows[i].opnd, rows[i].addr, rows[i].wr, rows[i].wd,
        rows[i].sel);
      chk("pc", rows[i].pc, pc);
      chk("low byte", 13'(rows[i].pc[7:0]), 13'(pc_low_reg));
      chk("latch", 13'h001B, 13'(lat));
    end
    $display("row table done");
    // nine pushes then nine pops: the ninth push lands on the oldest slot
    for (int i = 0; i < 9; i++) begin
      apply(pcs_pkg::PCS_OP_CALL, 11'(i * 8), 8'h7F, 1'b0, 8'h00, 3'h0);
    end
    for (int j = 0; j < 9; j++) begin
      apply(pcs_pkg::PCS_OP_RETURN, 11'h000, 8'h7F, 1'b0, 8'h00, 3'h0);
      chk("pop", 13'h1801 + 13'((7 - j % 8) * 8), pc);
    end
    $display("stack test done");
    apply(pcs_pkg::PCS_OP_NONE, 11'h000, 8'h0A, 1'b1, 8'h35, 3'h1);
    apply(pcs_pkg::PCS_OP_NONE, 11'h000, 8'h00, 1'b0, 8'h00, 3'h0);
    chk("ind read", 13'h0335, 13'({req.rd, req.addr}));
    chk("ind data", 13'h00A5, 13'(ird));
    apply(pcs_pkg::PCS_OP_NONE, 11'h000, 8'h00, 1'b1, 8'h5A, 3'h0);
    chk("ind write", 13'h015A, 13'({req.wr, req.wdata}));
    apply(pcs_pkg::PCS_OP_NONE, 11'h000, 8'h0A, 1'b1, 8'h00, 3'h1);
    apply(pcs_pkg::PCS_OP_NONE, 11'h000, 8'h00, 1'b0, 8'h00, 3'h0);
    chk("self read", 13'h0000, 13'({req.rd, ird}));
    apply(pcs_pkg::PCS_OP_NONE, 11'h000, 8'h00, 1'b1, 8'h77, 3'h0);
    chk("self write", 13'h0000, 13'(req.wr));
    $display("indirect test done");
    // a second reset in mid-run must clear the counter and the latch
    RESET = 1'b1;
    apply(pcs_pkg::PCS_OP_STEP, 11'h000, 8'h7F, 1'b0, 8'h00, 3'h0);
    chk("pc after reset", 13'h0000, pc);
    chk("latch after reset", 13'h0000, 13'(lat));
    // release again: the first step after release counts from zero
    RESET = 1'b0;
    apply(pcs_pkg::PCS_OP_STEP, 11'h000, 8'h7F, 1'b0, 8'h00, 3'h0);
    chk("pc after release", 13'h0001, pc);
    $display("reset test done");
    conclude();
  end
endmodule // tb_pcs_core
`default_nettype wire
